// ---- src/ufd_pkg.sv ----
/*
 * shared constants for the serial flag, ninth-bit and request-routing block:
 * register offsets, bit positions, reset values and timing figures.
 * assumes a 32-bit apb slave, one aligned word per register.
 */
package ufd_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] UFD_OFS_DATA   = 8'h00;  // data buffer register
    localparam logic [7:0] UFD_OFS_STAT1  = 8'h04;  // status register one
    localparam logic [7:0] UFD_OFS_CTRL3  = 8'h08;  // control register three
    localparam logic [7:0] UFD_OFS_CTRL2  = 8'h0C;  // control register two
    localparam logic [7:0] UFD_OFS_MODE   = 8'h10;  // character length select

    // ------------------------------------------------------------------
    // control register three bit positions
    // ------------------------------------------------------------------
    localparam int UFD_C3_RX9   = 7;  // received ninth bit, read only
    localparam int UFD_C3_TX9   = 6;  // transmit ninth bit
    localparam int UFD_C3_RDMA  = 5;
    localparam int UFD_C3_TDMA  = 4;
    localparam int UFD_C3_OVERRUN_IRQ_ENABLE  = 3;
    localparam int UFD_C3_NOISE_IRQ_ENABLE  = 2;
    localparam int UFD_C3_FRAMING_IRQ_ENABLE  = 1;
    localparam int UFD_C3_PARITY_IRQ_ENABLE  = 0;

    // ------------------------------------------------------------------
    // control register two bit positions
    // ------------------------------------------------------------------
    localparam int UFD_C2_TEIE  = 7;
    localparam int UFD_C2_TX_COMPLETE_IRQ_ENABLE  = 6;
    localparam int UFD_C2_RFIE  = 5;
    localparam int UFD_C2_LINE_QUIET_IRQ_ENABLE  = 4;
    localparam int UFD_C2_TXON  = 3;
    localparam int UFD_C2_RXON  = 2;

    // ------------------------------------------------------------------
    // status register one bit positions
    // ------------------------------------------------------------------
    localparam int UFD_S1_TXE   = 7;
    localparam int UFD_S1_TC    = 6;
    localparam int UFD_S1_RXF   = 5;
    localparam int UFD_S1_IDLE  = 4;
    localparam int UFD_S1_OVR   = 3;
    localparam int UFD_S1_NOIS  = 2;
    localparam int UFD_S1_FRM   = 1;
    localparam int UFD_S1_PAR   = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] UFD_CTRL3_RST = 6'h00;  // dma and error enables
    localparam logic [5:0] UFD_CTRL2_RST = 6'h00;
    localparam logic       UFD_TXE_RST   = 1'b1;
    localparam logic       UFD_TC_RST    = 1'b1;

    // ------------------------------------------------------------------
    // timing: idle line length in bit times, start latency of transmitter
    // ------------------------------------------------------------------
    localparam int UFD_IDLE_BITS_8   = 10;
    localparam int UFD_IDLE_BITS_9   = 11;
    localparam int UFD_TX_LAT_HALFCK = 3;  // 1.5 transmitter clocks, in halves

endpackage : ufd_pkg

// ---- src/ufd_core.sv ----
/*
 * status flag, ninth-bit and request-routing logic of a serial interface.
 * holds control registers two and three, status register one and the data
 * buffer, routes flags to cpu interrupts or dma requests, and runs the
 * status-read then data-access clearing sequences.
 * assumes an apb master on the register side, a dma engine that flags its
 * own data buffer accesses, and external shifters that pulse their events
 * synchronously to CLOCK_IN.
 */
//
// Overview of operation
// - nine-bit mode: received ninth bit readable, captured with the buffer byte
// - eight-bit mode: received ninth bit field copies received bit seven
// - nine-bit mode: transmit ninth bit goes to shifter with the buffer byte
// - reset keeps both ninth bits, clears both dma enables
// - receive dma enabled suppresses every receiver cpu interrupt
// - receive-full gives cpu interrupt without dma, dma request with it
// - transmit-empty gives cpu interrupt without dma, dma request with it
// - overrun raises error interrupt only while its enable is set
// - noise raises error interrupt only with its enable; reset clears enable
// - framing raises error interrupt only with its enable; reset clears enable
// - parity raises receiver interrupt only with its enable; reset clears enable
// - transmit-empty set on each buffer handover to shifter and by reset
// - transmit-empty cleared by status read then buffer write, or dma write
// - first transmitter enable sets transmit-empty; set tx dma first
// - transmit complete set when empty and idle, interrupts, set by reset
// - transmit complete clears on queueing or dma write; start may lag
// - receive-full set when shifter loads buffer, cleared by reset
// - receive-full cleared by status read then buffer read, or dma read
// - idle flag after ten or eleven ones; interrupts only without rx dma
// - idle flag rearms only after a character sets receive-full
// - overrun when character completes with receive-full set; new one lost
// - buffer read clears overrun only if set at preceding status read
// - length bit clear selects eight-bit, set selects nine-bit characters
module ufd_core
    import ufd_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              CLOCK_IN,
    input  wire logic              RSTN_IN,
    // apb slave
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [7:0]        PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    output logic [31:0]            PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    // dma engine accesses to the data buffer
    input  wire logic              DMA_RD_IN,
    input  wire logic              DMA_WR_IN,
    input  wire logic [DATA_W-1:0] DMA_WDATA_IN,
    output logic [DATA_W-1:0]      DMA_RDATA_OUT,
    // receive shifter side
    input  wire logic              RX_DONE_IN,
    input  wire logic [DATA_W:0]   RX_CHAR_IN,
    input  wire logic              RX_IDLE_IN,
    input  wire logic              RX_NOISE_IN,
    input  wire logic              RX_FRAME_IN,
    input  wire logic              RX_PARITY_IN,
    // transmit shifter side
    input  wire logic              TX_SHIFT_READY_IN,
    input  wire logic              TX_BUSY_IN,
    output logic                   TX_LOAD_OUT,
    output logic [DATA_W:0]        TX_CHAR_OUT,
    output logic                   TX_PREAMBLE_OUT,
    output logic                   NINE_BIT_OUT,
    // request routing
    output logic                   TX_IRQ_OUT,
    output logic                   RX_IRQ_OUT,
    output logic                   ERR_IRQ_OUT,
    output logic                   TX_DMA_REQ_OUT,
    output logic                   RX_DMA_REQ_OUT
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic              nine_bit_q;
    logic              rx9_q, tx9_q;          // ninth bits, no reset
    logic [5:0]        ctrl3_q;               // dma and error enables
    logic [5:0]        ctrl2_q;
    logic [DATA_W-1:0] rxbuf_q, txbuf_q;      // buffer, no reset
    logic              txbuf_full_q;
    logic              txe_q, tc_q, rxf_q, idle_q, ovr_q;
    logic              nois_q, frm_q, par_q;
    logic              idle_armed_q;
    logic              tx_started_q;          // first enable seen
    logic              preamble_q;
    logic [7:0]        armed_q;               // flags seen at status read
    logic [DATA_W:0]   tx_char_q;
    logic              tx_load_q;
    logic [31:0]       prdata_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire acc      = PSEL_IN && PENABLE_IN;
    wire wr       = acc && PWRITE_IN;
    wire rd       = acc && !PWRITE_IN;
    wire rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    wire hit_data = PADDR_IN == UFD_OFS_DATA;
    wire hit_st1  = PADDR_IN == UFD_OFS_STAT1;
    wire hit_c3   = PADDR_IN == UFD_OFS_CTRL3;
    wire hit_c2   = PADDR_IN == UFD_OFS_CTRL2;
    wire hit_mode = PADDR_IN == UFD_OFS_MODE;
    wire mapped   = hit_data | hit_st1 | hit_c3 | hit_c2 | hit_mode;

    wire st1_rd   = rd && hit_st1;
    wire cpu_drd  = rd && hit_data;
    wire cpu_dwr  = wr && hit_data;
    wire c3_wr    = wr && hit_c3;
    wire c2_wr    = wr && hit_c2;

    // ctrl3_q holds bits 5..0 of control register three
    wire rx_dma_en = ctrl3_q[5];
    wire tx_dma_en = ctrl3_q[4];
    wire overrun_irq_enable = ctrl3_q[3];
    wire noise_irq_enable = ctrl3_q[2];
    wire framing_irq_enable = ctrl3_q[1];
    wire parity_irq_enable = ctrl3_q[0];
    wire teie = ctrl2_q[5];
    wire tx_complete_irq_enable = ctrl2_q[4];
    wire rfie = ctrl2_q[3];
    wire line_quiet_irq_enable = ctrl2_q[2];
    wire txon = ctrl2_q[1];
    wire rxon = ctrl2_q[0];

    wire [7:0] stat1 = {txe_q, tc_q, rxf_q, idle_q, ovr_q, nois_q, frm_q, par_q};
    wire [7:0] ctrl3 = {rx9_q, tx9_q, ctrl3_q};
    wire [7:0] ctrl2 = {ctrl2_q, 2'b00};

    // ------------------------------------------------------------------
    // flag set and clearing events
    // ------------------------------------------------------------------
    wire txe_clr  = (cpu_dwr && armed_q[UFD_S1_TXE]) || DMA_WR_IN;
    wire rx_clr   = cpu_drd || DMA_RD_IN;
    wire new_txon = c2_wr && PWDATA_IN[UFD_C2_TXON] && !tx_started_q;
    wire tx_fill  = cpu_dwr || DMA_WR_IN;
    wire tx_hand  = txbuf_full_q && TX_SHIFT_READY_IN && txon && !preamble_q;
    wire rx_accept = RX_DONE_IN && rxon && !rxf_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [7:0] rd_byte = hit_data ? rxbuf_q[7:0] :
                         hit_st1  ? stat1 :
                         hit_c3   ? ctrl3 :
                         hit_c2   ? ctrl2 :
                         {7'h00, nine_bit_q};

    // ------------------------------------------------------------------
    // register and control writes
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctrl3_q      <= UFD_CTRL3_RST;
            ctrl2_q      <= UFD_CTRL2_RST;
            nine_bit_q   <= 1'b0;
            tx_started_q <= 1'b0;
            prdata_q     <= 32'h0000_0000;
        end else begin
            if (c3_wr)
                ctrl3_q <= PWDATA_IN[5:0];
            if (c2_wr)
                ctrl2_q <= PWDATA_IN[7:2];
            if (wr && hit_mode)
                nine_bit_q <= PWDATA_IN[0];
            if (new_txon)
                tx_started_q <= 1'b1;
            // captured in the setup cycle so read data stands at the access edge
            if (rd_setup)
                prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // ninth bits and buffers keep their value through reset
    always_ff @(posedge CLOCK_IN) begin
        if (c3_wr)
            tx9_q <= PWDATA_IN[UFD_C3_TX9];
        if (rx_accept)
            rx9_q <= nine_bit_q ? RX_CHAR_IN[DATA_W] : RX_CHAR_IN[DATA_W-1];
        if (rx_accept)
            rxbuf_q <= RX_CHAR_IN[DATA_W-1:0];
        if (cpu_dwr)
            txbuf_q <= PWDATA_IN[DATA_W-1:0];
        else if (DMA_WR_IN)
            txbuf_q <= DMA_WDATA_IN;
        if (tx_hand)
            tx_char_q <= {nine_bit_q & tx9_q, txbuf_q};
    end

    // ------------------------------------------------------------------
    // transmit flags; set wins over clear, except transmit complete where clear wins
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            txe_q        <= UFD_TXE_RST;
            tc_q         <= UFD_TC_RST;
            txbuf_full_q <= 1'b0;
            preamble_q   <= 1'b0;
            tx_load_q    <= 1'b0;
        end else begin
            tx_load_q <= tx_hand;
            if (tx_hand || new_txon)
                txe_q <= 1'b1;
            else if (txe_clr)
                txe_q <= 1'b0;
            if (tx_fill)
                txbuf_full_q <= 1'b1;
            else if (tx_hand)
                txbuf_full_q <= 1'b0;
            // preamble queued on each rising transmitter enable
            if (c2_wr && PWDATA_IN[UFD_C2_TXON] && !txon)
                preamble_q <= 1'b1;
            else if (TX_SHIFT_READY_IN)
                preamble_q <= 1'b0;
            // queueing anything drops complete at once; shifter lag is its own
            // pending load pulse counts as sending, else complete blips before busy
            if (tx_fill || tx_hand || tx_load_q || preamble_q || TX_BUSY_IN)
                tc_q <= 1'b0;
            else if (txe_q && !txbuf_full_q)
                tc_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // receive flags and arming
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rxf_q        <= 1'b0;
            idle_q       <= 1'b0;
            ovr_q        <= 1'b0;
            nois_q       <= 1'b0;
            frm_q        <= 1'b0;
            par_q        <= 1'b0;
            idle_armed_q <= 1'b0;
            armed_q      <= 8'h00;
        end else begin
            // status read arms the flags it saw; next cpu data access or dma read consumes
            // arm from the byte software was given, not a later flag state
            if (st1_rd)
                armed_q <= prdata_q[7:0];
            else if (rx_clr || cpu_dwr)
                armed_q <= 8'h00;
            if (rx_accept)
                rxf_q <= 1'b1;
            else if (rx_clr && (armed_q[UFD_S1_RXF] || DMA_RD_IN))
                rxf_q <= 1'b0;
            if (RX_DONE_IN && rxon && rxf_q)
                ovr_q <= 1'b1;
            else if (cpu_drd && armed_q[UFD_S1_OVR])
                ovr_q <= 1'b0;
            if (RX_IDLE_IN && idle_armed_q)
                idle_q <= 1'b1;
            else if (cpu_drd && armed_q[UFD_S1_IDLE])
                idle_q <= 1'b0;
            if (rx_accept)
                idle_armed_q <= 1'b1;
            else if ((RX_IDLE_IN && idle_armed_q) || (c2_wr && !rxon))
                idle_armed_q <= 1'b0;
            if (RX_NOISE_IN && RX_DONE_IN)
                nois_q <= 1'b1;
            else if (cpu_drd && armed_q[UFD_S1_NOIS])
                nois_q <= 1'b0;
            if (RX_FRAME_IN && RX_DONE_IN)
                frm_q <= 1'b1;
            else if (cpu_drd && armed_q[UFD_S1_FRM])
                frm_q <= 1'b0;
            if (RX_PARITY_IN && RX_DONE_IN)
                par_q <= 1'b1;
            else if (cpu_drd && armed_q[UFD_S1_PAR])
                par_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // request routing
    // ------------------------------------------------------------------
    // cpu reads of the buffer under dma can steal a request; software's risk
    assign TX_IRQ_OUT     = (txe_q && teie && !tx_dma_en)
                          || (tc_q && tx_complete_irq_enable);
    assign TX_DMA_REQ_OUT = txe_q && teie && tx_dma_en;
    assign RX_IRQ_OUT     = !rx_dma_en && (
                               (rxf_q && rfie)
                            || (idle_q && line_quiet_irq_enable)
                            || (par_q && parity_irq_enable));
    assign RX_DMA_REQ_OUT = rxf_q && rfie && rx_dma_en;
    assign ERR_IRQ_OUT    = (ovr_q && overrun_irq_enable)
                          || (nois_q && noise_irq_enable)
                          || (frm_q && framing_irq_enable);

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign PREADY_OUT      = 1'b1;           // zero-wait slave
    assign PSLVERR_OUT     = acc && !mapped;
    assign PRDATA_OUT      = prdata_q;
    assign DMA_RDATA_OUT   = rxbuf_q;
    assign TX_LOAD_OUT     = tx_load_q;
    assign TX_CHAR_OUT     = tx_char_q;
    assign TX_PREAMBLE_OUT = preamble_q;
    assign NINE_BIT_OUT    = nine_bit_q;

endmodule // ufd_core

// ---- bench/ufd_core_props.sv ----
/*
 * port-level assertions for the serial flag and request-routing core.
 * assumes one clock domain and the async active-low reset of the core.
 */
module ufd_core_props (
    input wire logic       CLOCK_IN,
    input wire logic       RSTN_IN,
    input wire logic       PSEL_IN,
    input wire logic       PENABLE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic       PREADY_OUT,
    input wire logic       PSLVERR_OUT,
    input wire logic       DMA_RD_IN,
    input wire logic       DMA_WR_IN,
    input wire logic       RX_DONE_IN,
    input wire logic       RX_IRQ_OUT,
    input wire logic       ERR_IRQ_OUT,
    input wire logic       RX_DMA_REQ_OUT,
    input wire logic       TX_DMA_REQ_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_zero_wait: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
        else $error("pready low in access");
    a_unmapped_err: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 8'h10 |-> PSLVERR_OUT)
        else $error("unmapped access not flagged");
    a_reset_quiet: assert property ($rose(RSTN_IN) |->
        !RX_IRQ_OUT && !ERR_IRQ_OUT && !RX_DMA_REQ_OUT && !TX_DMA_REQ_OUT)
        else $error("request active after reset");
    a_rx_route_excl: assert property (RX_DMA_REQ_OUT |-> !RX_IRQ_OUT)
        else $error("rx irq with rx dma");
    a_rx_dma_clr: assert property (RX_DMA_REQ_OUT && DMA_RD_IN && !RX_DONE_IN
        |=> !RX_DMA_REQ_OUT) else $error("dma read kept rx request");
    a_tx_dma_clr: assert property (TX_DMA_REQ_OUT && DMA_WR_IN |=> !TX_DMA_REQ_OUT)
        else $error("dma write kept tx request");
    a_ovr_keeps_full: assert property (RX_DONE_IN && RX_DMA_REQ_OUT && !DMA_RD_IN
        && !PSEL_IN |=> RX_DMA_REQ_OUT) else $error("overrun dropped full");
    a_rx_irq_hold: assert property (RX_IRQ_OUT && !PSEL_IN && !DMA_RD_IN
        |=> RX_IRQ_OUT) else $error("rx irq lost without clear");
    a_tx_req_hold: assert property (TX_DMA_REQ_OUT && !PSEL_IN && !DMA_WR_IN
        |=> TX_DMA_REQ_OUT) else $error("tx request lost without write");
    c_rx_dma: cover property (RX_DMA_REQ_OUT && DMA_RD_IN);
    c_tx_dma: cover property (TX_DMA_REQ_OUT && DMA_WR_IN);
    c_err_irq: cover property (ERR_IRQ_OUT);
endmodule // ufd_core_props

bind ufd_core ufd_core_props ufd_core_props_i (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .DMA_RD_IN(DMA_RD_IN), .DMA_WR_IN(DMA_WR_IN),
    .RX_DONE_IN(RX_DONE_IN), .RX_IRQ_OUT(RX_IRQ_OUT), .ERR_IRQ_OUT(ERR_IRQ_OUT),
    .RX_DMA_REQ_OUT(RX_DMA_REQ_OUT), .TX_DMA_REQ_OUT(TX_DMA_REQ_OUT));

// ---- bench/ufd_line_model.sv ----
/*
 * behavioural shifter pair facing the core: hands received characters
 * in and swallows transmitted ones. assumes the core clock.
 */
module ufd_line_model (
    input  wire logic       clk_in,
    input  wire logic       tx_load_in,
    input  wire logic [8:0] tx_char_in,
    output logic            rx_done_out,
    output logic [8:0]      rx_char_out,
    output logic            rx_idle_out,
    output logic [2:0]      rx_err_out,
    output logic            tx_ready_out,
    output logic            tx_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] last_tx_q;
    int         busy_q = 0;
    initial begin
        rx_done_out = 1'b0;
        rx_char_out = 9'h000;
        rx_idle_out = 1'b0;
        rx_err_out  = 3'h0;
    end
    // shifter stays busy one frame per load, so no second handover meanwhile
    always @(posedge clk_in) begin
        if (tx_load_in) begin
            last_tx_q <= tx_char_in;
            busy_q    <= 20;
        end else if (busy_q > 0) begin
            busy_q <= busy_q - 1;
        end
    end
    assign tx_busy_out  = (busy_q > 0);
    assign tx_ready_out = !tx_busy_out;
    // one character; data lines scrambled afterwards so stale values never match
    task automatic send(input logic [8:0] c, input logic [2:0] e);
        @(posedge clk_in);
        rx_done_out <= 1'b1;
        rx_char_out <= c;
        rx_err_out  <= e;
        @(posedge clk_in);
        rx_done_out <= 1'b0;
        rx_char_out <= ~c;
        rx_err_out  <= ~e;
    endtask
    task automatic idle();
        @(posedge clk_in);
        rx_idle_out <= 1'b1;
        @(posedge clk_in);
        rx_idle_out <= 1'b0;
    endtask
endmodule // ufd_line_model

// ---- bench/uart_flag_dma_control_tb.sv ----
/*
 * self-checking bench for the serial flag core: apb accesses, dma pulses
 * and a line model. assumes zero-wait apb and registered read data.
 */
module uart_flag_dma_control_tb
    import ufd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK_IN = 0, RSTN_IN = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, dwdata = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, dmard = 0, dmawr = 0, err_q, ld, pre, nine;
    logic tx_irq, rx_irq, err_irq, tx_req, rx_req, rdone, ridle, trdy, tbsy;
    logic [7:0] drd;
    logic [8:0] rch, tch;
    logic [2:0] rerr;
    int fails = 0, n_compared = 0, cyc = 0;
    ufd_core ufd_core_i (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .DMA_RD_IN(dmard), .DMA_WR_IN(dmawr), .DMA_WDATA_IN(dwdata), .DMA_RDATA_OUT(drd),
        .RX_DONE_IN(rdone), .RX_CHAR_IN(rch), .RX_IDLE_IN(ridle), .RX_NOISE_IN(rerr[2]),
        .RX_FRAME_IN(rerr[1]), .RX_PARITY_IN(rerr[0]), .TX_SHIFT_READY_IN(trdy),
        .TX_BUSY_IN(tbsy), .TX_LOAD_OUT(ld), .TX_CHAR_OUT(tch), .TX_PREAMBLE_OUT(pre),
        .NINE_BIT_OUT(nine), .TX_IRQ_OUT(tx_irq), .RX_IRQ_OUT(rx_irq),
        .ERR_IRQ_OUT(err_irq), .TX_DMA_REQ_OUT(tx_req), .RX_DMA_REQ_OUT(rx_req));
    ufd_line_model ufd_line_model_i (.clk_in(CLOCK_IN), .tx_load_in(ld),
        .tx_char_in(tch), .rx_done_out(rdone), .rx_char_out(rch), .rx_idle_out(ridle),
        .rx_err_out(rerr), .tx_ready_out(trdy), .tx_busy_out(tbsy));
    // ------------------------------------------------------------
    // clock, timeout, tasks
    // ------------------------------------------------------------
    initial begin
        forever #2.5 CLOCK_IN = ~CLOCK_IN;
    end
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge CLOCK_IN) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge CLOCK_IN);
        #1;
    endtask
    // apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK_IN);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge CLOCK_IN);
        penable <= 1'b1;
        do @(posedge CLOCK_IN);
        while (pready !== 1'b1);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge CLOCK_IN);
        #1;
    endtask
    task automatic dma(input logic rd);
        @(posedge CLOCK_IN);
        dmard <= rd;
        dmawr <= !rd;
        dwdata <= 8'h33;
        @(posedge CLOCK_IN);
        dmard <= 1'b0;
        dmawr <= 1'b0;
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge CLOCK_IN);
        RSTN_IN <= 1'b1;
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hC0, "stat reset");
        apb(0, UFD_OFS_CTRL3, 0); chk(r & 32'h3F, 0, "ctrl3 reset");
        apb(1, UFD_OFS_CTRL3, 32'h40);
        apb(1, UFD_OFS_MODE, 1); chk(nine, 1, "mode");
        apb(1, UFD_OFS_CTRL2, 32'h88); chk(tx_irq, 1, "tx irq");
        apb(0, UFD_OFS_STAT1, 0);
        apb(1, UFD_OFS_DATA, 32'h5A); w(30);
        chk(ufd_line_model_i.last_tx_q, 9'h15A, "tx char");
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hC0, "stat after tx");
        apb(1, UFD_OFS_CTRL3, 32'h50); chk(tx_req, 1, "tx dma");
        chk(tx_irq, 0, "tx irq off");
        dma(0); chk(tx_req, 0, "tx dma clr");
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'h80, "tc clr");
        w(30); chk(ufd_line_model_i.last_tx_q, 9'h133, "dma char");
        apb(1, UFD_OFS_CTRL3, 32'h48);
        apb(1, UFD_OFS_CTRL2, 32'h34);
        ufd_line_model_i.send(9'h1A5, 0); w(1); chk(rx_irq, 1, "rx irq");
        chk(err_irq, 0, "no err");
        apb(0, UFD_OFS_CTRL3, 0); chk(r[7], 1, "rx ninth");
        ufd_line_model_i.send(9'h0C3, 0); w(1); chk(err_irq, 1, "ovr irq");
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hE8, "stat ovr");
        apb(0, UFD_OFS_DATA, 0); chk(r[7:0], 8'hA5, "old data kept");
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hC0, "stat clr");
        ufd_line_model_i.idle(); w(1);
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hD0, "idle set");
        chk(rx_irq, 1, "idle irq");
        apb(0, UFD_OFS_DATA, 0);
        ufd_line_model_i.idle(); w(1);
        apb(0, UFD_OFS_STAT1, 0); chk(r, 32'hC0, "idle rearm");
        apb(1, UFD_OFS_MODE, 0);
        apb(1, UFD_OFS_CTRL2, 32'h04);
        ufd_line_model_i.send(9'h080, 3'h7); w(1); chk(err_irq, 0, "err masked");
        apb(0, UFD_OFS_CTRL3, 0); chk(r & 32'hC0, 32'hC0, "rx bit7 copy");
        for (int i = 1; i < 3; i++) begin
            apb(1, UFD_OFS_CTRL3, 32'h40 | (1 << i)); chk(err_irq, 1, "err irq");
        end
        apb(1, UFD_OFS_CTRL3, 32'h41); chk(rx_irq, 1, "par irq");
        apb(1, UFD_OFS_CTRL2, 32'h24);
        apb(1, UFD_OFS_CTRL3, 32'h61); chk(rx_irq, 0, "rx dma quiet");
        chk(rx_req, 1, "rx dma req");
        ufd_line_model_i.send(9'h011, 0); w(1); chk(rx_req, 1, "ovr keeps req");
        dma(1); chk(rx_req, 0, "rx dma clr");
        chk(drd, 8'h80, "dma data");
        apb(0, 8'h20, 0); chk(err_q, 1, "unmapped");
        @(posedge CLOCK_IN);
        RSTN_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        RSTN_IN <= 1'b1;
        apb(0, UFD_OFS_CTRL3, 0); chk(r, 32'hC0, "ninth kept");
        end_sim();
    end
endmodule // uart_flag_dma_control_tb
